// [pkg/sam_defs.svh]
// field positions, clock shift selects and timing counts of the sdram address map block
`ifndef SAM_DEFS_SVH
`define SAM_DEFS_SVH

// physical address bit that lands on column line 0
`define SAM_COL_LSB     3
// lowest bank select bit for a 1 KB page
`define SAM_BANK_LSB    10
// address line that selects all banks on a precharge
`define SAM_MA_ALLBANK  10
`define SAM_SHIFT_NONE  3'h0
`define SAM_SHIFT_HALF  3'h1
`define SAM_MEM_DIV     3
// timing counts below are in memory clock periods
`define SAM_CAS_LAT     2
`define SAM_T_RP        2
`define SAM_T_RCD       2
`define SAM_T_RFC       7
`define SAM_T_WR        2

`endif

// [pkg/sam_pkg.sv]
// types and shared decode for the sdram address map block
package sam_pkg;
    typedef logic [12:0] sam_row_t;
    typedef logic [8:0]  sam_col_t;

    typedef enum logic [6:0] {
        SAM_IDLE   = 7'h01,
        SAM_PREALL = 7'h02,
        SAM_RECOV  = 7'h04,
        SAM_PRE    = 7'h08,
        SAM_ACT    = 7'h10,
        SAM_WR2    = 7'h20,
        SAM_RDW    = 7'h40
    } sam_state_t;

    // encoded as {ras, cas, we}, all active low
    typedef enum logic [2:0] {
        CMD_NOP   = 3'h7,
        CMD_ACT   = 3'h3,
        CMD_READ  = 3'h5,
        CMD_WRITE = 3'h4,
        CMD_PRE   = 3'h2,
        CMD_REF   = 3'h1
    } sam_cmd_t;

    // bytes below the start offset inside the 64-bit word are masked
    function automatic logic [7:0] sam_lead_mask(input logic [2:0] off);
        logic [8:0] ones;
        ones = (9'h001 << off) - 9'h001;
        return ones[7:0];
    endfunction : sam_lead_mask
endpackage : sam_pkg

// [pkg/sam_map_if.sv]
// request address and per-dimm geometry in, sdram address fields out
`timescale 1ns/10ps
interface sam_map_if #(parameter int ADDR_W = 28) ();
    import sam_pkg::*;
    logic [ADDR_W-1:0] physAddr;
    logic [1:0]        pageSize;
    logic              fourBanks;
    logic              twoRanks;
    sam_row_t          row;
    sam_col_t          col;
    logic [1:0]        bank;
    logic              rank;
    logic [7:0]        byteMask;

    modport ctrl (output physAddr, pageSize, fourBanks, twoRanks, input row, col, bank, rank, byteMask);
    modport map  (input physAddr, pageSize, fourBanks, twoRanks, output row, col, bank, rank, byteMask);
endinterface : sam_map_if

// [core/sam_addr_map.sv]
// splits a physical address into row, column, bank and dimm bank fields
`timescale 1ns/10ps
`include "sam_defs.svh"
module sam_addr_map (
    sam_map_if.map mif
);
    import sam_pkg::*;

    logic [4:0] bankLsb;
    logic [4:0] rankBit;
    logic [4:0] rowLsb;
    logic [4:0] colTop;
    sam_col_t   colRaw;

    // every field sits above the previous one, so each page size step, the second bank bit and the dimm bank bit push the row up a bit
    always_comb begin
        bankLsb      = 5'(`SAM_BANK_LSB) + 5'(mif.pageSize);
        rankBit      = bankLsb + 5'(mif.fourBanks) + 5'h01;
        rowLsb       = rankBit + 5'(mif.twoRanks);
        mif.row      = sam_row_t'(mif.physAddr >> rowLsb);
        mif.bank     = mif.fourBanks ? {mif.physAddr[bankLsb + 5'h01], mif.physAddr[bankLsb]}
                                     : {1'b0, mif.physAddr[bankLsb]};
        mif.rank     = mif.twoRanks & mif.physAddr[rankBit];
        colTop       = 5'h07 + 5'(mif.pageSize);
        colRaw       = sam_col_t'(mif.physAddr >> `SAM_COL_LSB);
        mif.col      = colRaw & ~(9'h1FF << colTop);
        mif.byteMask = sam_lead_mask(mif.physAddr[2:0]);
    end
endmodule : sam_addr_map

// [core/sam_ctrl.sv]
// sdram controller core: command sequencing, page tracking and clock shift
`timescale 1ns/10ps
`include "sam_defs.svh"
// ****************************************************************
// ****************************************************************
module sam_ctrl #(
    parameter int ADDR_W  = 28,
    parameter int MEM_DIV = `SAM_MEM_DIV
) (
    input  wire  logic                 sys_clk,
    input  wire  logic                 srst,
    input  wire  logic                 reqValid,
    input  wire  logic                 reqWrite,
    input  wire  logic                 reqDimm,
    input  wire  logic [ADDR_W-1:0]    reqAddr,
    input  wire  logic [127:0]         reqWdata,
    input  wire  logic                 refReq,
    input  wire  logic [3:0]           pageSizeCfg,
    input  wire  logic [1:0]           fourBankCfg,
    input  wire  logic [1:0]           twoRankCfg,
    input  wire  logic [2:0]           clockShiftSel,
    output logic                       reqAck,
    output logic                       refAck,
    output logic                       rdValid,
    output logic [127:0]               rdData,
    output logic [1:0]                 sdramClockOut,
    output logic                       feedbackRefOut,
    input  wire  logic                 feedbackClockIn,
    output logic [1:0]                 dimmBankSelectLowN,
    output logic [1:0]                 dimmBankSelectHighN,
    output logic                       rasN,
    output logic                       casN,
    output logic                       weN,
    output logic [1:0]                 bankSelect,
    output sam_pkg::sam_row_t          rowColAddrLines,
    output logic [7:0]                 dqm,
    output logic [63:0]                dqOut,
    output logic                       dqOeN,
    input  wire  logic [63:0]          dqIn
);
    import sam_pkg::*;

    localparam logic [3:0] HALF  = 4'(MEM_DIV / 2);
    localparam logic [3:0] LAST  = 4'(MEM_DIV - 1);
    localparam logic [2:0] BEAT0 = 3'(`SAM_CAS_LAT + 1);
    localparam logic [2:0] BEAT1 = 3'(`SAM_CAS_LAT + 2);

    typedef struct packed {
        sam_state_t       state;
        logic [3:0]       divCnt;
        logic [3:0]       clkHist;
        logic             fire;
        sam_cmd_t         cmd;
        logic [3:0]       csN;
        logic [1:0]       ba;
        sam_row_t         ma;
        logic [7:0]       dqm;
        logic [63:0]      dqOut;
        logic             dqOeN;
        logic [3:0]       waitCnt;
        logic [2:0]       edgeCnt;
        logic [2:0]       fbSync;
        logic [63:0]      rdS0;
        logic [63:0]      rdS1;
        logic [127:0]     rdData;
        logic             rdValid;
        logic             reqAck;
        logic             refAck;
        logic             lastPreAll;
        logic [15:0]      openFlag;
        logic [15:0][12:0] openRow;
        logic             wr;
        logic [1:0]       cs;
        logic [1:0]       bank;
        sam_row_t         row;
        sam_col_t         col;
        logic [7:0]       mask;
        logic [127:0]     wData;
    } sam_ctrl_st_t;

    sam_ctrl_st_t st;
    sam_ctrl_st_t next_st;
    logic         memEn;
    logic         fbRise;
    logic [3:0]   hitIdx;
    logic [3:0]   clkHistN;
    logic         shiftedClk;

    sam_map_if #(.ADDR_W(ADDR_W)) mif ();

    // geometry of the addressed dimm only; each dimm may differ
    assign mif.physAddr  = reqAddr;
    assign mif.pageSize  = pageSizeCfg[{reqDimm, 1'b0} +: 2];
    assign mif.fourBanks = fourBankCfg[reqDimm];
    assign mif.twoRanks  = twoRankCfg[reqDimm];

    sam_addr_map u_map (
        .mif (mif)
    );

    assign memEn  = (st.divCnt == LAST);
    assign fbRise = st.fbSync[1] & ~st.fbSync[2];
    assign hitIdx = {mif.rank, reqDimm, mif.bank};

    // ****************************************************************
    // command issue helpers
    // ****************************************************************
    function automatic sam_ctrl_st_t issueAct(input sam_ctrl_st_t s);
        s.cmd                      = CMD_ACT;
        s.csN                      = ~(4'h1 << s.cs);
        s.ba                       = s.bank;
        s.ma                       = s.row;
        s.openFlag[{s.cs, s.bank}] = 1'b1;
        s.openRow[{s.cs, s.bank}]  = s.row;
        s.waitCnt                  = 4'(`SAM_T_RCD);
        s.lastPreAll               = 1'b0;
        s.state                    = SAM_ACT;
        return s;
    endfunction : issueAct

    function automatic sam_ctrl_st_t issueRw(input sam_ctrl_st_t s);
        s.cmd        = s.wr ? CMD_WRITE : CMD_READ;
        s.csN        = ~(4'h1 << s.cs);
        s.ba         = s.bank;
        s.ma         = sam_row_t'(s.col);
        s.dqm        = s.mask;
        s.dqOut      = s.wData[63:0];
        s.dqOeN      = ~s.wr;
        s.edgeCnt    = 3'h0;
        s.lastPreAll = 1'b0;
        s.state      = s.wr ? SAM_WR2 : SAM_RDW;
        return s;
    endfunction : issueRw

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st         = st;
        next_st.rdValid = 1'b0;
        next_st.reqAck  = 1'b0;
        next_st.refAck  = 1'b0;
        next_st.fire    = 1'b0;
        next_st.fbSync  = {st.fbSync[1:0], feedbackClockIn};
        next_st.rdS0    = dqIn;
        next_st.rdS1    = st.rdS0;
        next_st.divCnt  = memEn ? 4'h0 : st.divCnt + 4'h1;
        next_st.clkHist = {st.clkHist[2:0], (next_st.divCnt < HALF)};
        // read beats counted from the edge that sampled the read command
        if (st.state == SAM_RDW && fbRise) begin
            next_st.edgeCnt = st.edgeCnt + 3'h1;
            if (next_st.edgeCnt == BEAT0) begin
                next_st.rdData[63:0] = st.rdS1;
            end
            if (next_st.edgeCnt == BEAT1) begin
                next_st.rdData[127:64] = st.rdS1;
                next_st.rdValid        = 1'b1;
                next_st.state          = SAM_IDLE;
            end
        end
        // sdram command, address and data outputs only change together with the memory clock rise
        if (memEn) begin
            next_st.fire  = 1'b1;
            next_st.cmd   = CMD_NOP;
            next_st.csN   = 4'hF;
            next_st.dqOeN = 1'b1;
            next_st.dqm   = 8'h00;
            if (st.waitCnt != 4'h0) begin
                next_st.waitCnt = st.waitCnt - 4'h1;
            end
            case (st.state)
                SAM_IDLE: begin
                    if (refReq) begin
                        next_st.cmd        = CMD_PRE;
                        next_st.csN        = 4'h0;
                        next_st.ma         = sam_row_t'(1) << `SAM_MA_ALLBANK;
                        next_st.openFlag   = 16'h0000;
                        next_st.waitCnt    = 4'(`SAM_T_RP);
                        next_st.lastPreAll = 1'b1;
                        next_st.state      = SAM_PREALL;
                    end else if (reqValid) begin
                        next_st.wr     = reqWrite;
                        next_st.cs     = {mif.rank, reqDimm};
                        next_st.bank   = mif.bank;
                        next_st.row    = mif.row;
                        next_st.col    = mif.col;
                        next_st.mask   = mif.byteMask;
                        next_st.wData  = reqWdata;
                        next_st.reqAck = 1'b1;
                        if (st.openFlag[hitIdx] && st.openRow[hitIdx] == mif.row) begin
                            next_st = issueRw(next_st);
                        end else if (st.openFlag[hitIdx]) begin
                            next_st.cmd              = CMD_PRE;
                            next_st.csN              = ~(4'h1 << next_st.cs);
                            next_st.ba               = mif.bank;
                            next_st.ma               = sam_row_t'(0);
                            next_st.openFlag[hitIdx] = 1'b0;
                            next_st.waitCnt          = 4'(`SAM_T_RP);
                            next_st.lastPreAll       = 1'b0;
                            next_st.state            = SAM_PRE;
                        end else begin
                            next_st = issueAct(next_st);
                        end
                    end
                end
                SAM_PREALL: begin
                    if (st.waitCnt == 4'h0) begin
                        next_st.cmd     = CMD_REF;
                        next_st.csN     = 4'h0;
                        next_st.refAck  = 1'b1;
                        next_st.waitCnt = 4'(`SAM_T_RFC);
                        next_st.state   = SAM_RECOV;
                    end
                end
                SAM_PRE: begin
                    if (st.waitCnt == 4'h0) begin
                        next_st = issueAct(next_st);
                    end
                end
                SAM_ACT: begin
                    if (st.waitCnt == 4'h0) begin
                        next_st = issueRw(next_st);
                    end
                end
                SAM_WR2: begin
                    next_st.dqOut   = st.wData[127:64];
                    next_st.dqOeN   = 1'b0;
                    next_st.waitCnt = 4'(`SAM_T_WR);
                    next_st.state   = SAM_RECOV;
                end
                SAM_RECOV: begin
                    if (st.waitCnt == 4'h0) begin
                        next_st.state = SAM_IDLE;
                    end
                end
                SAM_RDW: begin
                    next_st.waitCnt = 4'h0;
                end
                default: begin
                    next_st.state = SAM_IDLE;
                end
            endcase
        end
        if (srst) begin
            next_st       = '0;
            next_st.state = SAM_IDLE;
            next_st.cmd   = CMD_NOP;
            next_st.csN   = 4'hF;
            next_st.dqOeN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // ****************************************************************
    // sdram clock shift
    // ****************************************************************
    // falling-edge copy gives the half core clock steps; the select is static so the mux cannot glitch
    always_ff @(negedge sys_clk) begin
        if (srst) begin
            clkHistN <= 4'h0;
        end else begin
            clkHistN <= st.clkHist;
        end
    end

    assign shiftedClk = clockShiftSel[0] ? clkHistN[clockShiftSel[2:1]]
                                         : st.clkHist[clockShiftSel[2:1]];

    assign sdramClockOut       = {2{shiftedClk}};
    assign feedbackRefOut      = shiftedClk;
    assign dimmBankSelectLowN  = st.csN[1:0];
    assign dimmBankSelectHighN = st.csN[3:2];
    assign {rasN, casN, weN}   = st.cmd;
    assign bankSelect          = st.ba;
    assign rowColAddrLines     = st.ma;
    assign dqm                 = st.dqm;
    assign dqOut               = st.dqOut;
    assign dqOeN               = st.dqOeN;
    assign rdData              = st.rdData;
    assign rdValid             = st.rdValid;
    assign reqAck              = st.reqAck;
    assign refAck              = st.refAck;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_row_two_bank: assert property (reqValid && pageSizeCfg[1:0] == 2'h0 && !reqDimm && !fourBankCfg[0]
        && !twoRankCfg[0] |-> mif.row == reqAddr[23:11] && mif.bank == {1'b0, reqAddr[10]} && !mif.rank)
        else $error("row or bank split wrong for two banks");
    a_row_four_bank: assert property (reqValid && pageSizeCfg[3:2] == 2'h2 && reqDimm && fourBankCfg[1]
        && !twoRankCfg[1] |-> mif.row == reqAddr[26:14] && mif.bank == reqAddr[13:12])
        else $error("row or bank split wrong for four banks");
    a_col_lines: assert property (reqValid && pageSizeCfg[1:0] == 2'h0 && !reqDimm
        |-> mif.col == {2'h0, reqAddr[9:3]})
        else $error("column lines wrong");
    a_rank_split: assert property (reqValid && pageSizeCfg[1:0] == 2'h0 && !reqDimm && twoRankCfg[0]
        && !fourBankCfg[0] |-> mif.row == reqAddr[24:12] && mif.rank == reqAddr[11] && mif.bank[0] == reqAddr[10])
        else $error("dimm bank split wrong");
    a_byte_mask: assert property (st.reqAck |-> st.mask == sam_lead_mask($past(reqAddr[2:0])))
        else $error("byte mask does not follow low address bits");
    a_read_open: assert property (st.fire && st.cmd == CMD_READ
        |-> st.openFlag[{st.cs, st.bank}] && st.openRow[{st.cs, st.bank}] == st.row)
        else $error("read issued into a row that is not open");
    a_write_burst: assert property (st.fire && st.cmd == CMD_WRITE && !st.dqOeN
        |-> ##[1:16] (st.fire && !st.dqOeN && st.dqOut == st.wData[127:64]))
        else $error("second write beat missing");
    a_ref_preall: assert property (st.fire && st.cmd == CMD_REF |-> st.lastPreAll && $past(st.state) == SAM_PREALL)
        else $error("refresh without precharge all");
    a_act_closed: assert property (memEn && next_st.cmd == CMD_ACT
        |-> !st.openFlag[{next_st.cs, next_st.bank}])
        else $error("activate into a bank with a row open");
    a_launch_edge: assert property ($rose(st.clkHist[0]) |-> st.fire)
        else $error("outputs not launched on memory clock rise");
    a_shift_none: assert property (clockShiftSel == `SAM_SHIFT_NONE |-> sdramClockOut == {2{st.clkHist[0]}})
        else $error("unshifted sdram clock wrong");
    a_shift_half: assert property (clockShiftSel == `SAM_SHIFT_HALF |-> sdramClockOut[0] == clkHistN[0])
        else $error("half shift sdram clock wrong");
    a_read_capture: assert property (st.rdValid |-> $past(fbRise))
        else $error("read data not taken on feedback rise");
endmodule : sam_ctrl

// [sim/sam_sdram_model.sv]
// dimm model: feedback trace, write capture and read return
`timescale 1ns/10ps
module sam_sdram_model
    import sam_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [3:0]  csN,
    input  wire logic [2:0]  cmd,
    input  wire logic [1:0]  ba,
    input  wire logic [12:0] ma,
    input  wire logic [63:0] dqOut,
    output logic             fbClk,
    output logic [63:0]      dq
);
    logic [63:0] mem [int];
    // board trace; commands and write data are sampled on this delayed rise
    assign #1 fbClk = clk;
    initial dq = 64'h0;
    task automatic rdBurst(input int k);
        @(posedge fbClk);
        // beats sit centred on the rise the controller captures them at
        @(negedge fbClk) dq = mem.exists(k) ? mem[k] : {32'hA5A5A5A5, k};
        @(negedge fbClk) dq = mem.exists(k + 1) ? mem[k + 1] : ~dq;
        // a released bus never shows the last beat
        @(negedge fbClk) dq = ~dq;
    endtask : rdBurst
    always @(posedge fbClk) begin
        automatic int k = {csN, ba, ma[8:0], 1'b0};
        if (csN != 4'hF && cmd == CMD_WRITE) begin
            mem[k] = dqOut;
            @(posedge fbClk) mem[k + 1] = dqOut;
        end
        if (csN != 4'hF && cmd == CMD_READ) fork
            rdBurst(k);
        join_none
    end
endmodule : sam_sdram_model

// [sim/tb_top.sv]
// testbench: address split, command order, read return and clock shift
`timescale 1ns/10ps
module tb_top;
    import sam_pkg::*;
    typedef struct packed {
        logic [2:0]  cmd;
        logic [3:0]  csN;
        logic [1:0]  ba;
        logic [12:0] ma;
        logic [7:0]  dqm;
    } sam_ent_t;
    logic sys_clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqDimm = 1'b0, refReq = 1'b0;
    logic [27:0]  reqAddr = 28'h0;
    logic [127:0] reqWdata = 128'h0, rdData;
    logic [2:0]   clockShiftSel = 3'h0;
    logic [1:0]   twoRankCfg = 2'h1;
    logic reqAck, refAck, rdValid, feedbackRefOut, feedbackClockIn, rasN, casN, weN, dqOeN;
    logic [1:0]   sdramClockOut, dimmBankSelectLowN, dimmBankSelectHighN, bankSelect;
    sam_row_t     rowColAddrLines;
    logic [7:0]   dqm;
    logic [63:0]  dqOut, dqIn;
    sam_ent_t     seen [$];
    realtime      lastEdge;
    int err_count = 0, total_checks = 0, cycles = 0;
    always #10 sys_clk = ~sys_clk;
    // dimm0: 1 KB pages, two banks, two dimm banks; dimm1: 4 KB pages, four banks, one dimm bank
    sam_ctrl dut_u (.sys_clk, .srst, .reqValid, .reqWrite, .reqDimm, .reqAddr, .reqWdata, .refReq,
        .pageSizeCfg(4'h8), .fourBankCfg(2'h2), .twoRankCfg, .clockShiftSel, .reqAck, .refAck,
        .rdValid, .rdData, .sdramClockOut, .feedbackRefOut, .feedbackClockIn, .dimmBankSelectLowN,
        .dimmBankSelectHighN, .rasN, .casN, .weN, .bankSelect, .rowColAddrLines, .dqm, .dqOut, .dqOeN, .dqIn);
    sam_sdram_model sdram_u (.clk(feedbackRefOut), .csN({dimmBankSelectHighN, dimmBankSelectLowN}),
        .cmd({rasN, casN, weN}), .ba(bankSelect), .ma(rowColAddrLines), .dqOut, .fbClk(feedbackClockIn), .dq(dqIn));
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    always @(posedge sys_clk) begin
        lastEdge = $realtime;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    // one entry per non-NOP command: commands last a whole memory clock
    always @(posedge feedbackClockIn)
        if (!srst && {rasN, casN, weN} != CMD_NOP)
            seen.push_back({rasN, casN, weN, dimmBankSelectHighN, dimmBankSelectLowN, bankSelect, rowColAddrLines, dqm});
    task automatic waitFor(input int sel);
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((sel == 0 ? reqAck : sel == 1 ? refAck : rdValid) !== 1'b1 && n < 300);
        chk(n < 300, 1'b1);
    endtask : waitFor
    task automatic req(input logic wr, input logic dimm, input logic [27:0] a, input logic [127:0] d);
        seen.delete();
        @(posedge sys_clk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqDimm <= dimm;
        reqAddr <= a;
        reqWdata <= d;
        waitFor(0);
        reqValid <= 1'b0;
        if (wr) repeat (45) @(posedge sys_clk);
        else waitFor(2);
    endtask : req
    task automatic shiftChk(input logic [2:0] s, input int expNs);
        realtime t;
        clockShiftSel <= s;
        repeat (20) @(posedge sys_clk);
        @(posedge sdramClockOut[0]);
        t = $realtime;
        chk(int'(t - lastEdge), expNs);
        #1 chk({sdramClockOut[1], feedbackRefOut}, 2'b11);
        @(posedge sdramClockOut[0]);
        chk(int'($realtime - t), 60);
    endtask : shiftChk
    task automatic dimmZero();
        logic [27:0] a = 28'h1234D63;
        logic [27:0] b = a + 28'h1000;
        logic [3:0] cs = ~(4'h1 << (2 * a[11]));
        logic [1:0] ba = {1'b0, a[10]};
        req(1'b1, 1'b0, a, {64'h1122334455667788, 64'h99AABBCCDDEEFF00});
        chk(seen[0], {CMD_ACT, cs, ba, 13'(a[24:12]), 8'h00});
        chk(seen[1], {CMD_WRITE, cs, ba, 13'(a[9:3]), 8'h07});
        req(1'b0, 1'b0, a, 128'h0);
        chk({seen.size(), seen[0]}, {32'd1, CMD_READ, cs, ba, 13'(a[9:3]), 8'h07});
        chk(rdData, {64'h1122334455667788, 64'h99AABBCCDDEEFF00});
        req(1'b0, 1'b0, b, 128'h0);
        chk({seen[0].cmd, seen[0].ma[10]}, {CMD_PRE, 1'b0});
        chk(seen[1], {CMD_ACT, cs, ba, 13'(b[24:12]), 8'h00});
        chk(seen[2].cmd, CMD_READ);
        seen.delete();
        refReq <= 1'b1;
        waitFor(1);
        refReq <= 1'b0;
        repeat (45) @(posedge sys_clk);
        chk({seen.size(), seen[0].cmd, seen[0].csN, seen[0].ma[10]}, {32'd2, CMD_PRE, 4'h0, 1'b1});
        chk({seen[1].cmd, seen[1].csN}, {CMD_REF, 4'h0});
        req(1'b0, 1'b0, a, 128'h0);
        chk({seen[0].cmd, seen[1].cmd}, {CMD_ACT, CMD_READ});
        chk(rdData, {64'h1122334455667788, 64'h99AABBCCDDEEFF00});
    endtask : dimmZero
    task automatic dimmOne();
        logic [27:0] c = 28'h5A7F3A0;
        req(1'b1, 1'b1, c, {64'h0F1E2D3C4B5A6978, 64'h8796A5B4C3D2E1F0});
        chk(seen[0], {CMD_ACT, 4'hD, c[13:12], 13'(c[26:14]), 8'h00});
        chk(seen[1], {CMD_WRITE, 4'hD, c[13:12], 13'(c[11:3]), 8'h00});
        req(1'b0, 1'b1, c, 128'h0);
        chk(rdData, {64'h0F1E2D3C4B5A6978, 64'h8796A5B4C3D2E1F0});
    endtask : dimmOne
    // dimm0 reconfigured to a single dimm bank while idle: row drops one bit, no chip select bit
    task automatic oneRank();
        logic [27:0] e = 28'h0ABCDE8;
        twoRankCfg <= 2'h0;
        req(1'b1, 1'b0, e, {64'h0, 64'h5});
        chk(seen[0], {CMD_ACT, 4'hE, 1'b0, e[10], 13'(e[23:11]), 8'h00});
        chk(seen[1], {CMD_WRITE, 4'hE, 1'b0, e[10], 13'(e[9:3]), 8'h00});
    endtask : oneRank
    initial begin
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        shiftChk(3'h0, 0);
        dimmZero();
        shiftChk(3'h1, 10);
        dimmOne();
        oneRank();
        conclude();
    end
endmodule : tb_top
